// ==== hw/bfcs_pkg.sv ====
// Constants and types shared by the fast-charge sequencer
`default_nettype none
package bfcs_pkg;
	// Base clock
	localparam int CLK_MHZ = 125;
	localparam int SEC_CYCLES = CLK_MHZ * 1000000;

	// Three-level timer mode input, digitised
	localparam logic [1:0] TM_LOW  = 2'h0;
	localparam logic [1:0] TM_MID  = 2'h1;
	localparam logic [1:0] TM_HIGH = 2'h2;

	// Battery sense code: 14 bits, 250 uV per step
	localparam int ADC_W = 14;
	localparam int ADC_LSB_UV = 250;
	localparam int NDV_DROP_UV = 12000;
	localparam int PVD_DROP_UV = 2500;
	localparam int DET_LOW_UV = 1000000;
	localparam int DET_HIGH_UV = 2000000;
	localparam logic [ADC_W-1:0] NDV_DROP_CODE = ADC_W'(NDV_DROP_UV / ADC_LSB_UV);
	localparam logic [ADC_W-1:0] PVD_DROP_CODE = ADC_W'(PVD_DROP_UV / ADC_LSB_UV);
	localparam logic [ADC_W-1:0] DET_LOW_CODE = ADC_W'(DET_LOW_UV / ADC_LSB_UV);
	localparam logic [ADC_W-1:0] DET_HIGH_CODE = ADC_W'(DET_HIGH_UV / ADC_LSB_UV);

	// Voltage sampling
	localparam int SAMPLE_INTERVAL_S = 17;
	localparam int MEAS_SPACING_US = 570;
	localparam int MEAS_CNT_PVD = 32;
	localparam int MEAS_CNT_NDV = 16;
	localparam int MEAS_SHIFT_PVD = $clog2(MEAS_CNT_PVD);
	localparam int MEAS_SHIFT_NDV = $clog2(MEAS_CNT_NDV);

	// Current modulation
	localparam int PULSE_ON_US = 286;
	localparam int TOPOFF_OFF_US = 4290;
	localparam real TRICKLE_OFF_FULL_MS = 18.0;
	localparam real TRICKLE_OFF_HALF_MS = 8.86;

	// Safety time limits (minutes) and hold-off (seconds) per rate
	localparam int LIMIT_HALF_MIN = 160;
	localparam int LIMIT_1C_MIN = 80;
	localparam int LIMIT_2C_MIN = 40;
	localparam int HOLDOFF_HALF_S = 600;
	localparam int HOLDOFF_1C_S = 300;
	localparam int HOLDOFF_2C_S = 150;

	// APB register map
	localparam logic [11:0] REG_CTRL   = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_SAMPLE = 12'h008;
	localparam int CTRL_INH_BIT = 0;

	typedef enum logic [2:0] {
		ST_START,
		ST_FAST,
		ST_TOPOFF,
		ST_TRICKLE,
		ST_LOWPWR
	} bfcs_state_type;
endpackage
`default_nettype wire

// ==== hw/bfcs_sequencer.sv ====
// Fast-charge sequencer: charge phases, terminations, modulation, APB access
//
// Contract
// - High mode: end fast charge when sample is 12mV below highest sample.
// - Low or mid mode: end fast charge on 2.5mV drop from peak.
// - Voltage-slope tests only while sample lies strictly between 1V and 2V.
// - One voltage sample every 17 seconds.
// - Sample averages measurements 570us apart: 32 peak mode, 16 delta mode.
// - Hold-off at fast charge start disables voltage-slope terminations.
// - Maximum voltage and temperature terminations stay active during hold-off.
// - Battery above max cell voltage ends fast charge or top-off.
// - Temperature below cutoff ends charging.
// - Safety timer on fast charge, cleared and reapplied on top-off; not trickle.
// - Top-off only for C/2 and 1C rate selections.
// - Top-off pulses current on 286us, off 4290us, repeating.
// - Top-off ends only on max voltage, max time, max temperature; the code also leaves top-off for low power on power-down.
// - Trickle: on 286us, off 18.0ms for 1C/2C, 8.86ms for C/2.
// - Timer mode selects limit, top-off, slope mode, trickle rate, hold-off.
// - Status pin pulled low only during fast charge, else released.
// - Inhibit suspends fast charge, top-off and timer; status pin held.
// - During inhibit keep temperature watch and pulse-trickle per mode.
// - Leaving inhibit resumes exactly where suspended.
// - Above power-down threshold: low power, both open-drain pins released.
// - After low power, pulse-trickle until a new charge cycle starts.
// - Current control released lets current flow; pulled low stops it.
// - New cycle at power-up or battery falling through max cell voltage.
// - Fast charge only if voltage and temperature in limits, else trickle.
`default_nettype none
module bfcs_sequencer #(
	parameter int P_SEC_CYCLES = bfcs_pkg::SEC_CYCLES,
	parameter int P_MEAS_SPACING_CYC = bfcs_pkg::MEAS_SPACING_US * bfcs_pkg::CLK_MHZ,
	parameter int P_PULSE_ON_CYC = bfcs_pkg::PULSE_ON_US * bfcs_pkg::CLK_MHZ,
	parameter int P_TOPOFF_OFF_CYC = bfcs_pkg::TOPOFF_OFF_US * bfcs_pkg::CLK_MHZ,
	parameter int P_TRICKLE_OFF_FULL_CYC =
		$rtoi(bfcs_pkg::TRICKLE_OFF_FULL_MS * 1000.0 * bfcs_pkg::CLK_MHZ),
	parameter int P_TRICKLE_OFF_HALF_CYC =
		$rtoi(bfcs_pkg::TRICKLE_OFF_HALF_MS * 1000.0 * bfcs_pkg::CLK_MHZ)
) (
	input  wire logic                       i_sys_clk,
	input  wire logic                       i_reset_n,
	input  wire logic [1:0]                 i_timer_mode_select,
	input  wire logic                       i_charge_inhibit_input,
	input  wire logic [bfcs_pkg::ADC_W-1:0] i_battery_sense_input,
	input  wire logic                       i_bat_above_max_cell,
	input  wire logic                       i_ts_below_temp_cutoff,
	input  wire logic                       i_bat_above_power_down,
	input  wire logic                       i_charge_current_control_in,
	output logic                            o_charge_current_control_out,
	output logic                            o_charge_current_control_oe,
	input  wire logic                       i_charge_status_output_in,
	output logic                            o_charge_status_output_out,
	output logic                            o_charge_status_output_oe,
	input  wire logic                       i_psel,
	input  wire logic                       i_penable,
	input  wire logic                       i_pwrite,
	input  wire logic [11:0]                i_paddr,
	input  wire logic [31:0]                i_pwdata,
	output logic [31:0]                     o_prdata,
	output logic                            o_pready,
	output logic                            o_pslverr
);
	localparam int SEC_W = $clog2(P_SEC_CYCLES);
	localparam int MSP_W = $clog2(P_MEAS_SPACING_CYC);
	localparam int PER_MAX = P_PULSE_ON_CYC + P_TRICKLE_OFF_FULL_CYC;
	localparam int PUL_W = $clog2(PER_MAX + 1);
	localparam int ACC_W = bfcs_pkg::ADC_W + bfcs_pkg::MEAS_SHIFT_PVD;

	generate
		if (P_SEC_CYCLES < 2 || P_MEAS_SPACING_CYC < 2 || P_PULSE_ON_CYC < 1
			|| P_TOPOFF_OFF_CYC < 1 || P_TRICKLE_OFF_HALF_CYC < 1
			|| P_TOPOFF_OFF_CYC > P_TRICKLE_OFF_FULL_CYC
			|| P_TRICKLE_OFF_HALF_CYC > P_TRICKLE_OFF_FULL_CYC)
		begin : g_bad_param
			$error("bfcs_sequencer: timing parameters out of range");
		end
	endgenerate

	bfcs_pkg::bfcs_state_type state_reg;
	bfcs_pkg::bfcs_state_type state_next;
	logic [SEC_W-1:0]          sec_cnt_reg;
	logic                      sec_tick;
	logic [13:0]               timer_sec_reg;
	logic [4:0]                samp_sec_reg;
	logic                      burst_reg;
	logic [MSP_W-1:0]          msp_cnt_reg;
	logic [5:0]                meas_idx_reg;
	logic [ACC_W-1:0]          acc_reg;
	logic [ACC_W-1:0]          acc_sum;
	logic [bfcs_pkg::ADC_W-1:0] avg;
	logic [bfcs_pkg::ADC_W-1:0] peak_reg;
	logic                      peak_valid_reg;
	logic [bfcs_pkg::ADC_W-1:0] sample_reg;
	logic                      sample_done;
	logic                      vterm;
	logic [PUL_W-1:0]          pulse_cnt_reg;
	logic [PUL_W-1:0]          period_end;
	logic                      pulse_on;
	logic                      mcv_prev_reg;
	logic                      inh_prev_reg;
	logic                      ctrl_inh_reg;
	logic                      cc_oe_reg;
	logic                      status_oe_reg;
	logic                      mode_high;
	logic                      mode_mid;
	logic                      topoff_en;
	logic                      inhibit;
	logic                      running;
	logic                      holdoff;
	logic                      timeout;
	logic                      in_window;
	logic [bfcs_pkg::ADC_W-1:0] drop;
	logic [5:0]                meas_last;
	int                        limit_s;
	int                        holdoff_s;
	logic                      access;
	logic                      mapped;

	// Mode decode; an undefined code falls back to the mid setting
	always_comb
	begin
		mode_high = (i_timer_mode_select == bfcs_pkg::TM_HIGH);
		mode_mid = !mode_high && (i_timer_mode_select != bfcs_pkg::TM_LOW);
		topoff_en = !mode_high;
		if (mode_high)
		begin
			limit_s = bfcs_pkg::LIMIT_2C_MIN * 60;
			holdoff_s = bfcs_pkg::HOLDOFF_2C_S;
		end
		else if (mode_mid)
		begin
			limit_s = bfcs_pkg::LIMIT_HALF_MIN * 60;
			holdoff_s = bfcs_pkg::HOLDOFF_HALF_S;
		end
		else
		begin
			limit_s = bfcs_pkg::LIMIT_1C_MIN * 60;
			holdoff_s = bfcs_pkg::HOLDOFF_1C_S;
		end
	end

	assign inhibit = i_charge_inhibit_input | ctrl_inh_reg;
	assign running = ((state_reg == bfcs_pkg::ST_FAST) || (state_reg == bfcs_pkg::ST_TOPOFF))
		&& !inhibit;
	assign timeout = (int'(timer_sec_reg) >= limit_s);
	assign holdoff = (state_reg == bfcs_pkg::ST_FAST) && (int'(timer_sec_reg) < holdoff_s);

	// One-second base tick, free running
	assign sec_tick = (sec_cnt_reg == SEC_W'(P_SEC_CYCLES - 1));
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n || sec_tick)
			sec_cnt_reg <= '0;
		else
			sec_cnt_reg <= sec_cnt_reg + 1'b1;
	end

	// Sequencing
	always_comb
	begin
		state_next = state_reg;
		if (i_bat_above_power_down)
			state_next = bfcs_pkg::ST_LOWPWR;
		else
		begin
			case (state_reg)
				bfcs_pkg::ST_START:
					if (!i_bat_above_max_cell && !i_ts_below_temp_cutoff)
						state_next = bfcs_pkg::ST_FAST;
					else
						state_next = bfcs_pkg::ST_TRICKLE;
				bfcs_pkg::ST_FAST:
					if (i_ts_below_temp_cutoff)
						state_next = bfcs_pkg::ST_TRICKLE;
					else if (!inhibit && i_bat_above_max_cell)
						state_next = bfcs_pkg::ST_TRICKLE;
					else if (!inhibit && (timeout || vterm))
						state_next = topoff_en ? bfcs_pkg::ST_TOPOFF : bfcs_pkg::ST_TRICKLE;
				bfcs_pkg::ST_TOPOFF:
					if (i_ts_below_temp_cutoff
						|| (!inhibit && (i_bat_above_max_cell || timeout)))
						state_next = bfcs_pkg::ST_TRICKLE;
				bfcs_pkg::ST_TRICKLE:
					if (mcv_prev_reg && !i_bat_above_max_cell)
						state_next = bfcs_pkg::ST_START;
				bfcs_pkg::ST_LOWPWR:
					state_next = bfcs_pkg::ST_TRICKLE;
				default:
					state_next = bfcs_pkg::ST_TRICKLE;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
			state_reg <= bfcs_pkg::ST_START;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
		begin
			mcv_prev_reg <= 1'b0;
			inh_prev_reg <= 1'b0;
		end
		else
		begin
			mcv_prev_reg <= i_bat_above_max_cell;
			inh_prev_reg <= inhibit;
		end
	end

	// Safety timer: cleared on every phase change, frozen under inhibit
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n || (state_reg != state_next))
			timer_sec_reg <= '0;
		else if (running && sec_tick && !timeout)
			timer_sec_reg <= timer_sec_reg + 1'b1;
	end

	// Voltage sampling: bursts of spaced measurements averaged by shift
	assign meas_last = mode_high ? 6'(bfcs_pkg::MEAS_CNT_NDV - 1)
		: 6'(bfcs_pkg::MEAS_CNT_PVD - 1);
	assign acc_sum = acc_reg + ACC_W'(i_battery_sense_input);
	assign avg = mode_high ? acc_sum[bfcs_pkg::MEAS_SHIFT_NDV +: bfcs_pkg::ADC_W]
		: acc_sum[bfcs_pkg::MEAS_SHIFT_PVD +: bfcs_pkg::ADC_W];
	assign sample_done = running && (state_reg == bfcs_pkg::ST_FAST) && burst_reg
		&& (msp_cnt_reg == '0) && (meas_idx_reg == meas_last);

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n || (state_reg != bfcs_pkg::ST_FAST) || (state_next != state_reg))
		begin
			samp_sec_reg <= '0;
			burst_reg <= 1'b0;
			msp_cnt_reg <= '0;
			meas_idx_reg <= '0;
			acc_reg <= '0;
		end
		else if (running)
		begin
			if (sec_tick)
				samp_sec_reg <= (samp_sec_reg == 5'(bfcs_pkg::SAMPLE_INTERVAL_S - 1))
					? '0 : samp_sec_reg + 1'b1;
			if (sec_tick && (samp_sec_reg == 5'(bfcs_pkg::SAMPLE_INTERVAL_S - 1)))
			begin
				burst_reg <= 1'b1;
				msp_cnt_reg <= '0;
				meas_idx_reg <= '0;
				acc_reg <= '0;
			end
			else if (burst_reg)
			begin
				msp_cnt_reg <= (msp_cnt_reg == MSP_W'(P_MEAS_SPACING_CYC - 1))
					? '0 : msp_cnt_reg + 1'b1;
				if (msp_cnt_reg == '0)
				begin
					acc_reg <= sample_done ? '0 : acc_sum;
					meas_idx_reg <= meas_idx_reg + 1'b1;
					if (sample_done)
						burst_reg <= 1'b0;
				end
			end
		end
	end

	// Slope terminations against the running peak
	assign in_window = (avg > bfcs_pkg::DET_LOW_CODE) && (avg < bfcs_pkg::DET_HIGH_CODE);
	assign drop = mode_high ? bfcs_pkg::NDV_DROP_CODE : bfcs_pkg::PVD_DROP_CODE;
	assign vterm = sample_done && in_window && !holdoff && peak_valid_reg
		&& (peak_reg > avg) && ((peak_reg - avg) >= drop);

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n || (state_reg == bfcs_pkg::ST_START))
		begin
			peak_reg <= '0;
			peak_valid_reg <= 1'b0;
		end
		else if (sample_done && in_window && !holdoff
			&& (!peak_valid_reg || (avg > peak_reg)))
		begin
			peak_reg <= avg;
			peak_valid_reg <= 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
			sample_reg <= '0;
		else if (sample_done)
			sample_reg <= avg;
	end

	// Modulation; period restarts on each phase or inhibit change
	always_comb
	begin
		if ((state_reg == bfcs_pkg::ST_TOPOFF) && !inhibit)
			period_end = PUL_W'(P_PULSE_ON_CYC + P_TOPOFF_OFF_CYC - 1);
		else if (mode_mid)
			period_end = PUL_W'(P_PULSE_ON_CYC + P_TRICKLE_OFF_HALF_CYC - 1);
		else
			period_end = PUL_W'(P_PULSE_ON_CYC + P_TRICKLE_OFF_FULL_CYC - 1);
	end
	assign pulse_on = (pulse_cnt_reg < PUL_W'(P_PULSE_ON_CYC));

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n || (state_reg != state_next) || (inhibit != inh_prev_reg)
			|| (pulse_cnt_reg >= period_end))
			pulse_cnt_reg <= '0;
		else
			pulse_cnt_reg <= pulse_cnt_reg + 1'b1;
	end

	// Open-drain pins; pulling CC low stops the charge current
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
			cc_oe_reg <= 1'b1;
		else if (state_reg == bfcs_pkg::ST_LOWPWR)
			cc_oe_reg <= 1'b0;
		else if (state_reg == bfcs_pkg::ST_START)
			cc_oe_reg <= 1'b1;
		else if ((state_reg == bfcs_pkg::ST_FAST) && !inhibit)
			cc_oe_reg <= 1'b0;
		else
			cc_oe_reg <= !pulse_on;
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
			status_oe_reg <= 1'b0;
		else if (state_reg == bfcs_pkg::ST_LOWPWR)
			status_oe_reg <= 1'b0;
		else if (!inhibit)
			status_oe_reg <= (state_reg == bfcs_pkg::ST_FAST);
	end

	assign o_charge_current_control_oe = cc_oe_reg;
	assign o_charge_current_control_out = 1'b0;
	assign o_charge_status_output_oe = status_oe_reg;
	assign o_charge_status_output_out = 1'b0;

	// APB slave, zero wait states
	assign access = i_psel && i_penable;
	assign mapped = (i_paddr == bfcs_pkg::REG_CTRL) || (i_paddr == bfcs_pkg::REG_STATUS)
		|| (i_paddr == bfcs_pkg::REG_SAMPLE);
	assign o_pready = 1'b1;
	assign o_pslverr = access && !mapped;

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
			ctrl_inh_reg <= 1'b0;
		else if (access && i_pwrite && (i_paddr == bfcs_pkg::REG_CTRL))
			ctrl_inh_reg <= i_pwdata[bfcs_pkg::CTRL_INH_BIT];
	end

	always_comb
	begin
		o_prdata = 32'h0000_0000;
		if (i_psel && !i_pwrite)
		begin
			case (i_paddr)
				bfcs_pkg::REG_CTRL:
					o_prdata = {31'h0, ctrl_inh_reg};
				bfcs_pkg::REG_STATUS:
					o_prdata = {22'h0, i_charge_status_output_in, i_charge_current_control_in,
						peak_valid_reg, holdoff, inhibit, timeout, 1'b0, state_reg};
				bfcs_pkg::REG_SAMPLE:
					o_prdata = {18'h0, sample_reg};
				default:
					o_prdata = 32'h0000_0000;
			endcase
		end
	end

	// Checks
	AST_STATUS_FAST: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		(state_reg != bfcs_pkg::ST_FAST) && !inhibit |=> !o_charge_status_output_oe)
		else $error("status pin driven outside fast charge");
	AST_STATUS_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		inhibit && (state_reg != bfcs_pkg::ST_LOWPWR) |=> $stable(o_charge_status_output_oe))
		else $error("status pin changed during inhibit");
	AST_TIMER_FREEZE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		inhibit && (state_next == state_reg) |=> $stable(timer_sec_reg))
		else $error("timer advanced during inhibit");
	AST_LOWPWR_HIZ: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_bat_above_power_down ##1 i_bat_above_power_down |=>
			!o_charge_current_control_oe && !o_charge_status_output_oe)
		else $error("pins driven in low power");
	AST_MCV_TERM: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		(state_reg == bfcs_pkg::ST_FAST || state_reg == bfcs_pkg::ST_TOPOFF) && !inhibit
		&& i_bat_above_max_cell && !i_bat_above_power_down
		|=> state_reg == bfcs_pkg::ST_TRICKLE)
		else $error("max cell voltage did not end charge");
	AST_TEMP_TERM: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		(state_reg == bfcs_pkg::ST_FAST || state_reg == bfcs_pkg::ST_TOPOFF)
		&& i_ts_below_temp_cutoff && !i_bat_above_power_down
		|=> state_reg == bfcs_pkg::ST_TRICKLE)
		else $error("temperature cutoff did not end charge");
	AST_FAST_CC: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		(state_reg == bfcs_pkg::ST_FAST) && !inhibit |=> !o_charge_current_control_oe)
		else $error("current blocked during fast charge");
	AST_TOPOFF_RATE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		$rose(state_reg == bfcs_pkg::ST_TOPOFF) |-> !mode_high)
		else $error("top-off entered at 2C rate");
	AST_HOLDOFF: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		holdoff |-> !vterm)
		else $error("slope termination during hold-off");
	AST_PULSE_ON: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		(state_reg == bfcs_pkg::ST_TRICKLE) && (state_next == state_reg)
		&& (pulse_cnt_reg == '0) && (inhibit == inh_prev_reg)
		|=> !o_charge_current_control_oe)
		else $error("trickle pulse not started");

	COV_FAST: cover property (@(posedge i_sys_clk) $rose(state_reg == bfcs_pkg::ST_FAST));
	COV_TOPOFF: cover property (@(posedge i_sys_clk) $rose(state_reg == bfcs_pkg::ST_TOPOFF));
	COV_VTERM: cover property (@(posedge i_sys_clk) vterm);
	COV_LOWPWR: cover property (@(posedge i_sys_clk) $rose(state_reg == bfcs_pkg::ST_LOWPWR));
endmodule
`default_nettype wire

// ==== tb/bfcs_partner.sv ====
// Partner: pulled-up open-drain pins and current pulse timing
`default_nettype none
module bfcs_partner (
	input  wire logic i_sys_clk,
	input  wire logic i_cc_oe,
	input  wire logic i_cc_out,
	input  wire logic i_led_oe,
	input  wire logic i_led_out,
	output logic      o_cc_wire,
	output logic      o_led_wire,
	output int        o_on_len,
	output int        o_off_len
);
	timeunit 1ns;
	timeprecision 1ps;
	int run;
	bit prev_oe;
	// Pull-ups win once released; a released control pin lets current flow
	assign o_cc_wire = i_cc_oe ? i_cc_out : 1'b1;
	assign o_led_wire = i_led_oe ? i_led_out : 1'b1;
	// Length of the last completed flow and stop runs, in clocks
	always @(posedge i_sys_clk)
	begin
		if (i_cc_oe == prev_oe)
			run <= run + 1;
		else
		begin
			if (prev_oe)
				o_off_len <= run;
			else
				o_on_len <= run;
			run <= 1;
		end
		prev_oe <= i_cc_oe;
	end
endmodule
`default_nettype wire

// ==== tb/battery_fast_charge_sequencer_tb.sv ====
// Self-checking bench for the fast-charge sequencer
`default_nettype none
module battery_fast_charge_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst_n, charge_inhibit_input, maxc, hot, pdn, psel, pen, pwr;
	logic [1:0]  mode;
	logic [13:0] battery_sense_input;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, cc_oe, led_oe, cc_w, led_w, cc_out, led_out;
	int          on_len, off_len, mismatches, checked;

	// Short counts: 8 clocks per second keeps the 40 minute limit reachable
	localparam int SEC      = 8;
	localparam int SPACING  = 4;
	localparam int ON       = 3;
	localparam int TOP_OFF  = 8;
	localparam int FULL_OFF = 12;
	localparam int HALF_OFF = 6;

	bfcs_sequencer #(.P_SEC_CYCLES(SEC), .P_MEAS_SPACING_CYC(SPACING), .P_PULSE_ON_CYC(ON),
		.P_TOPOFF_OFF_CYC(TOP_OFF), .P_TRICKLE_OFF_FULL_CYC(FULL_OFF),
		.P_TRICKLE_OFF_HALF_CYC(HALF_OFF)) uut (
		.i_sys_clk(clk), .i_reset_n(rst_n), .i_timer_mode_select(mode),
		.i_charge_inhibit_input(charge_inhibit_input), .i_battery_sense_input(battery_sense_input),
		.i_bat_above_max_cell(maxc), .i_ts_below_temp_cutoff(hot),
		.i_bat_above_power_down(pdn), .i_charge_current_control_in(cc_w),
		.o_charge_current_control_out(cc_out), .o_charge_current_control_oe(cc_oe),
		.i_charge_status_output_in(led_w), .o_charge_status_output_out(led_out),
		.o_charge_status_output_oe(led_oe), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr));

	bfcs_partner far (.i_sys_clk(clk), .i_cc_oe(cc_oe), .i_cc_out(cc_out),
		.i_led_oe(led_oe), .i_led_out(led_out), .o_cc_wire(cc_w), .o_led_wire(led_w),
		.o_on_len(on_len), .o_off_len(off_len));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task final_report;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	// One APB transfer; entered just after a rising edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		// Only the watchdog ends a wait for the slave
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask

	// Poll the state field up to n reads
	task st(input logic [2:0] s, input int n);
		logic [31:0] d;
		logic        e;
		int          i;
		i = 0;
		do
		begin
			apb(1'b0, bfcs_pkg::REG_STATUS, 32'h0, d, e);
			i++;
		end
		while (d[2:0] !== s && i < n);
		chk("state", {29'h0, s}, {29'h0, d[2:0]});
	endtask

	task pulses(input int on, input int off);
		repeat (3 * (on + off) + 10) @(posedge clk);
		chk("flow_len", on, on_len);
		chk("stop_len", off, off_len);
	endtask

	task rst(input logic [1:0] m, input logic [13:0] b);
		mode <= m;
		battery_sense_input <= b;
		maxc <= 1'b0;
		hot <= 1'b0;
		rst_n <= 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask

	task t_start;
		logic [31:0] d;
		logic        e;
		rst(bfcs_pkg::TM_LOW, 14'h1770);
		st(bfcs_pkg::ST_FAST, 5);
		chk("led", 32'h0, {31'h0, led_w});
		chk("cc", 32'h1, {31'h0, cc_w});
		apb(1'b0, 12'h00c, 32'h0, d, e);
		chk("slverr", 32'h1, {31'h0, e});
		chk("unmapped", 32'h0, d);
		apb(1'b1, bfcs_pkg::REG_CTRL, 32'h1, d, e);
		apb(1'b0, bfcs_pkg::REG_CTRL, 32'h0, d, e);
		chk("ctrl", 32'h1, d);
		st(bfcs_pkg::ST_FAST, 1);
		chk("led", 32'h0, {31'h0, led_w});
		pulses(ON, FULL_OFF);
		apb(1'b1, bfcs_pkg::REG_CTRL, 32'h0, d, e);
		st(bfcs_pkg::ST_FAST, 1);
		chk("cc", 32'h1, {31'h0, cc_w});
		charge_inhibit_input <= 1'b1;
		pulses(ON, FULL_OFF);
		st(bfcs_pkg::ST_FAST, 1);
		chk("led", 32'h0, {31'h0, led_w});
		charge_inhibit_input <= 1'b0;
		st(bfcs_pkg::ST_FAST, 1);
		$display("test start done");
	endtask

	task t_limits;
		maxc <= 1'b1;
		st(bfcs_pkg::ST_TRICKLE, 5);
		chk("led", 32'h1, {31'h0, led_w});
		pulses(ON, FULL_OFF);
		maxc <= 1'b0;
		st(bfcs_pkg::ST_FAST, 5);
		hot <= 1'b1;
		st(bfcs_pkg::ST_TRICKLE, 5);
		maxc <= 1'b1;
		repeat (2) @(posedge clk);
		maxc <= 1'b0;
		repeat (4) @(posedge clk);
		st(bfcs_pkg::ST_TRICKLE, 1);
		pdn <= 1'b1;
		st(bfcs_pkg::ST_LOWPWR, 5);
		chk("cc", 32'h1, {31'h0, cc_w});
		chk("led", 32'h1, {31'h0, led_w});
		pdn <= 1'b0;
		st(bfcs_pkg::ST_TRICKLE, 5);
		$display("test limits done");
	endtask

	task t_pvd;
		rst(bfcs_pkg::TM_MID, 14'h1770);
		repeat (1500) @(posedge clk);
		battery_sense_input <= 14'h170c;
		repeat (2800) @(posedge clk);
		st(bfcs_pkg::ST_FAST, 1);
		battery_sense_input <= 14'h2328;
		repeat (1000) @(posedge clk);
		battery_sense_input <= 14'h22c4;
		repeat (600) @(posedge clk);
		st(bfcs_pkg::ST_FAST, 1);
		// Just under the window top: a mixed sample can never sit 10 codes above it
		battery_sense_input <= 14'h1f36;
		repeat (600) @(posedge clk);
		st(bfcs_pkg::ST_FAST, 1);
		battery_sense_input <= 14'h1f2c;
		st(bfcs_pkg::ST_TOPOFF, 300);
		pulses(ON, TOP_OFF);
		maxc <= 1'b1;
		st(bfcs_pkg::ST_TRICKLE, 5);
		pulses(ON, HALF_OFF);
		$display("test pvd done");
	endtask

	task t_ndv;
		logic [31:0] d;
		logic        e;
		rst(bfcs_pkg::TM_HIGH, 14'h1770);
		repeat (1600) @(posedge clk);
		apb(1'b0, bfcs_pkg::REG_SAMPLE, 32'h0, d, e);
		chk("sample", 32'h1770, d);
		battery_sense_input <= 14'h1748;
		repeat (400) @(posedge clk);
		st(bfcs_pkg::ST_FAST, 1);
		battery_sense_input <= 14'h1740;
		st(bfcs_pkg::ST_TRICKLE, 300);
		$display("test ndv done");
	endtask

	task t_timeout;
		logic [31:0] d;
		logic        e;
		rst(bfcs_pkg::TM_HIGH, 14'h2328);
		repeat (19000) @(posedge clk);
		st(bfcs_pkg::ST_FAST, 1);
		st(bfcs_pkg::ST_TRICKLE, 300);
		apb(1'b0, bfcs_pkg::REG_STATUS, 32'h0, d, e);
		// Timer is cleared on leaving fast charge; trickle has no limit
		chk("timeout", 32'h0, {31'h0, d[4]});
		$display("test timeout done");
	endtask

	initial
	begin
		rst_n = 1'b0;
		mode = bfcs_pkg::TM_LOW;
		charge_inhibit_input = 1'b0;
		battery_sense_input = 14'h1770;
		maxc = 1'b0;
		hot = 1'b0;
		pdn = 1'b0;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		mismatches = 0;
		checked = 0;
		t_start();
		t_limits();
		t_pvd();
		t_ndv();
		t_timeout();
		final_report();
	end

	// Tests need about 29000 clocks
	initial
	begin
		repeat (70000) @(posedge clk);
		mismatches++;
		final_report();
	end
endmodule
`default_nettype wire
